// ---- design/contact_pkg.sv ----
// Purpose: Shared constants and types for the output contact control block
// Assumes: 20 MHz ref_clk, contacts pulled up so open reads high
// Notes: Register map reached over a plain strobe port
package contact_pkg;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_EVENT = 4'h2;
  localparam logic [3:0] ADDR_MASK = 4'h3;
  localparam logic [3:0] ADDR_DELAY = 4'h4;
  localparam logic [1:0] POL_HIGH_ON = 2'h0;
  localparam logic [1:0] POL_LOW_ON = 2'h1;
  localparam logic [1:0] POL_DISABLED = 2'h2;
  localparam logic [1:0] POL_RESET = 2'h2;
  localparam logic [7:0] MSG_NONE = 8'h00;
  localparam logic [7:0] MSG_HIGH_ON_CONFLICT = 8'h01;
  localparam logic [7:0] MSG_LOW_ON_CONFLICT = 8'h02;
  localparam int EV_SHUTDOWN = 0;
  localparam int EV_MSG = 1;
  localparam int EV_TRIP = 2;
  localparam int EV_CLEAR = 3;
  localparam int EV_W = 4;
  localparam logic [3:0] EV_RESET = 4'h0;
  localparam logic [15:0] DELAY_RESET = 16'h0000;
  localparam int CLK_HZ = 20000000;
  localparam int DEBOUNCE_US = 1000;
  localparam int DEBOUNCE_CYC = CLK_HZ / 1000000 * DEBOUNCE_US;
  localparam int DELAY_TICK_US = 1000;
  localparam int DELAY_TICK_CYC = CLK_HZ / 1000000 * DELAY_TICK_US;

  typedef struct packed {
    logic output_switch_input;
    logic shutdown_input;
    logic alarm_clear_input;
  } contacts_t;

  typedef struct packed {
    logic alarm_n;
    logic cv_n;
    logic power_off_n;
    logic cc_n;
    logic output_on_n;
  } status_pins_t;
endpackage

// ---- design/contact_filter.sv ----
// Purpose: Synchroniser and debounce for one contact input
// Assumes: Input is asynchronous, pulled up when open
// Notes: Output changes only after the input is steady for the full count
`timescale 1ns/1ps
`default_nettype none
module contact_filter #(
  parameter int STABLE_CYC = contact_pkg::DEBOUNCE_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic pin_in,
  output logic level
);
  logic sync1_reg;
  logic sync2_reg;
  logic [$clog2(STABLE_CYC+1)-1:0] cnt_reg;

  // Two flops; only the second is looked at downstream
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
    end
    else
    begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
    end
  end

  // Idle high because an open contact reads high
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      level <= 1'b1;
      cnt_reg <= '0;
    end
    else if (sync2_reg == level)
      cnt_reg <= '0;
    else if (cnt_reg == ($clog2(STABLE_CYC+1))'(STABLE_CYC - 1))
    begin
      level <= sync2_reg;
      cnt_reg <= '0;
    end
    else
      cnt_reg <= cnt_reg + 1'b1;
  end
endmodule // contact_filter
`default_nettype wire

// ---- design/output_contact_control.sv ----
// Purpose: Output on/off, shutdown and alarm clear from external contacts
// Assumes: Contacts to common with pull-ups; panel keys are 1-cycle pulses
// Notes: Polarity register is sampled into the live setting only at reset
//
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module output_contact_control #(
  parameter int DEBOUNCE_CYCLES = contact_pkg::DEBOUNCE_CYC,
  parameter int DELAY_TICK_CYCLES = contact_pkg::DELAY_TICK_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire contact_pkg::contacts_t contact_pins,
  input wire logic output_key,
  input wire logic alarm_clear_key,
  input wire logic protection_trip,
  input wire logic cv_mode,
  input wire logic cc_mode,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  output logic output_enable,
  output logic [7:0] message,
  output logic message_valid,
  output contact_pkg::status_pins_t status_pins,
  output logic irq
);
  typedef enum {ST_OFF, ST_ON_WAIT, ST_ON, ST_OFF_WAIT} out_state_t;

  logic sw_level;
  logic sd_level;
  logic clr_level;
  logic [1:0] pol_cfg_reg = contact_pkg::POL_RESET;
  logic [1:0] pol_live_reg;
  logic pol_take_reg;
  logic [15:0] on_delay_reg;
  logic [15:0] off_delay_reg;
  logic panel_on_reg;
  logic shutdown_latch_reg;
  logic alarm_latch_reg;
  logic [contact_pkg::EV_W-1:0] event_reg;
  logic [contact_pkg::EV_W-1:0] event_next;
  logic [contact_pkg::EV_W-1:0] mask_reg;
  logic [contact_pkg::EV_W-1:0] ev_set;
  out_state_t state_reg;
  logic [15:0] delay_cnt_reg;
  logic [$clog2(DELAY_TICK_CYCLES+1)-1:0] tick_cnt_reg;
  logic tick;
  logic contact_on;
  logic contact_ctrl;
  logic want_on;
  logic msg_pulse;
  logic [7:0] msg_code;
  logic clear_req;
  logic sd_prev_reg;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] b);
    hit = (a == b);
  endfunction

  // One filter per contact; three instances of the same structure
  contact_filter #(.STABLE_CYC(DEBOUNCE_CYCLES)) u_sw (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin_in(contact_pins.output_switch_input),
    .level(sw_level)
  );
  contact_filter #(.STABLE_CYC(DEBOUNCE_CYCLES)) u_sd (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin_in(contact_pins.shutdown_input),
    .level(sd_level)
  );
  contact_filter #(.STABLE_CYC(DEBOUNCE_CYCLES)) u_clr (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin_in(contact_pins.alarm_clear_input),
    .level(clr_level)
  );

  // Stored polarity is the power-on setting; rst stands for a power cycle,
  // so it must keep this copy and only reload the live one below
  always_ff @(posedge ref_clk)
  begin
    if (wr && hit(addr, contact_pkg::ADDR_CTRL))
      pol_cfg_reg <= wdata[1:0];
  end

  // Live polarity latched once after reset release
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      pol_live_reg <= contact_pkg::POL_RESET;
      pol_take_reg <= 1'b1;
    end
    else if (pol_take_reg)
    begin
      pol_live_reg <= pol_cfg_reg;
      pol_take_reg <= 1'b0;
    end
  end

  // Panel delay settings, used only under panel control
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      on_delay_reg <= contact_pkg::DELAY_RESET;
      off_delay_reg <= contact_pkg::DELAY_RESET;
    end
    else if (wr && hit(addr, contact_pkg::ADDR_DELAY))
    begin
      on_delay_reg <= {8'h00, wdata[7:0]};
      off_delay_reg <= {8'h00, wdata[15:8]};
    end
  end

  // Contact decode; polarity 3 treated like disabled
  always_comb
  begin
    contact_ctrl = 1'b0;
    contact_on = 1'b0;
    case (pol_live_reg)
      contact_pkg::POL_HIGH_ON:
      begin
        contact_ctrl = 1'b1;
        contact_on = sw_level;
      end
      contact_pkg::POL_LOW_ON:
      begin
        contact_ctrl = 1'b1;
        contact_on = ~sw_level;
      end
      default:
      begin
        contact_ctrl = 1'b0;
        contact_on = 1'b0;
      end
    endcase
  end

  // Output key conflict messages
  always_comb
  begin
    msg_pulse = 1'b0;
    msg_code = contact_pkg::MSG_NONE;
    if (output_key && pol_live_reg == contact_pkg::POL_HIGH_ON && !sw_level)
    begin
      msg_pulse = 1'b1;
      msg_code = contact_pkg::MSG_HIGH_ON_CONFLICT;
    end
    else if (output_key && pol_live_reg == contact_pkg::POL_LOW_ON
             && sw_level)
    begin
      msg_pulse = 1'b1;
      msg_code = contact_pkg::MSG_LOW_ON_CONFLICT;
    end
  end

  // Message register holds the last code until another key press
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      message <= contact_pkg::MSG_NONE;
      message_valid <= 1'b0;
    end
    else
    begin
      message_valid <= msg_pulse;
      if (msg_pulse)
        message <= msg_code;
      else if (output_key)
        message <= contact_pkg::MSG_NONE;
    end
  end

  // Panel toggle; a conflicting press does not enable the output
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      panel_on_reg <= 1'b0;
    else if (shutdown_latch_reg)
      panel_on_reg <= 1'b0;
    else if (output_key && !contact_ctrl)
      panel_on_reg <= ~panel_on_reg;
  end

  assign clear_req = alarm_clear_key || !clr_level;

  // Shutdown latch: set by low input, released only when open plus clear
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      shutdown_latch_reg <= 1'b0;
    else if (!sd_level)
      shutdown_latch_reg <= 1'b1;
    else if (clear_req)
      shutdown_latch_reg <= 1'b0;
  end

  // Protection alarm latch; a new trip wins over a clear
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      alarm_latch_reg <= 1'b0;
    else if (protection_trip)
      alarm_latch_reg <= 1'b1;
    else if (clear_req)
      alarm_latch_reg <= 1'b0;
  end

  assign want_on = contact_ctrl ? contact_on : panel_on_reg;

  // Delay timebase, one tick per millisecond
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      tick_cnt_reg <= '0;
    else if (tick)
      tick_cnt_reg <= '0;
    else
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
  end
  assign tick = (tick_cnt_reg ==
    ($clog2(DELAY_TICK_CYCLES+1))'(DELAY_TICK_CYCLES - 1));

  // Output sequencer; contact control bypasses the delays entirely
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= ST_OFF;
      delay_cnt_reg <= '0;
    end
    else if (shutdown_latch_reg || alarm_latch_reg)
    begin
      state_reg <= ST_OFF;
      delay_cnt_reg <= '0;
    end
    else if (contact_ctrl)
    begin
      state_reg <= want_on ? ST_ON : ST_OFF;
      delay_cnt_reg <= '0;
    end
    else
    begin
      case (state_reg)
        ST_OFF:
          if (want_on)
          begin
            state_reg <= ST_ON_WAIT;
            delay_cnt_reg <= on_delay_reg;
          end
        ST_ON_WAIT:
          if (!want_on)
            state_reg <= ST_OFF;
          else if (delay_cnt_reg == 16'h0000)
            state_reg <= ST_ON;
          else if (tick)
            delay_cnt_reg <= delay_cnt_reg - 16'h0001;
        ST_ON:
          if (!want_on)
          begin
            state_reg <= ST_OFF_WAIT;
            delay_cnt_reg <= off_delay_reg;
          end
        ST_OFF_WAIT:
          if (want_on)
            state_reg <= ST_ON;
          else if (delay_cnt_reg == 16'h0000)
            state_reg <= ST_OFF;
          else if (tick)
            delay_cnt_reg <= delay_cnt_reg - 16'h0001;
        default:
          state_reg <= ST_OFF;
      endcase
    end
  end

  assign output_enable = (state_reg == ST_ON) || (state_reg == ST_OFF_WAIT);

  // Status pins: all active low
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      status_pins <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
    else
    begin
      status_pins.alarm_n <= ~(alarm_latch_reg || !sd_level
                               || shutdown_latch_reg);
      status_pins.cv_n <= ~(cv_mode && output_enable);
      status_pins.power_off_n <= 1'b1; // Unit is powered while clocked
      status_pins.cc_n <= ~(cc_mode && output_enable);
      status_pins.output_on_n <= ~output_enable;
    end
  end

  // Event sources, registered edge of shutdown
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      sd_prev_reg <= 1'b1;
    else
      sd_prev_reg <= sd_level;
  end

  always_comb
  begin
    ev_set = '0;
    ev_set[contact_pkg::EV_SHUTDOWN] = sd_prev_reg && !sd_level;
    ev_set[contact_pkg::EV_MSG] = msg_pulse;
    ev_set[contact_pkg::EV_TRIP] = protection_trip;
    ev_set[contact_pkg::EV_CLEAR] = clear_req
      && (alarm_latch_reg || shutdown_latch_reg);
  end

  // Sticky events: write one to clear, a new event wins
  always_comb
  begin
    event_next = event_reg;
    if (wr && hit(addr, contact_pkg::ADDR_EVENT))
      event_next = event_reg & ~wdata[contact_pkg::EV_W-1:0];
    event_next = event_next | ev_set;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      event_reg <= contact_pkg::EV_RESET;
      mask_reg <= contact_pkg::EV_RESET;
    end
    else
    begin
      event_reg <= event_next;
      if (wr && hit(addr, contact_pkg::ADDR_MASK))
        mask_reg <= wdata[contact_pkg::EV_W-1:0];
    end
  end

  assign irq = |(event_reg & mask_reg);

  // Read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      rdata <= 16'h0000;
    else if (rd)
    begin
      case (addr)
        contact_pkg::ADDR_CTRL:
          rdata <= {10'h000, pol_live_reg, 2'h0, pol_cfg_reg};
        contact_pkg::ADDR_STATUS:
          rdata <= {9'h000, output_enable, alarm_latch_reg,
                    shutdown_latch_reg, panel_on_reg, clr_level,
                    sd_level, sw_level};
        contact_pkg::ADDR_EVENT:
          rdata <= {12'h000, event_reg};
        contact_pkg::ADDR_MASK:
          rdata <= {12'h000, mask_reg};
        contact_pkg::ADDR_DELAY:
          rdata <= {off_delay_reg[7:0], on_delay_reg[7:0]};
        default:
          rdata <= 16'h0000;
      endcase
    end
    else
      rdata <= 16'h0000;
  end
endmodule // output_contact_control
`default_nettype wire

// ---- testbench/contact_monitor.sv ----
// Purpose: Concurrent checks on the contact control block ports
// Assumes: Bound into output_contact_control, one clock domain
// Notes: Shutdown check window sized for a debounce count of 4
`timescale 1ns/1ps
`default_nettype none
module contact_monitor #(
  parameter int DEBOUNCE_CYCLES = 4
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire contact_pkg::contacts_t contact_pins,
  input wire logic output_key,
  input wire logic protection_trip,
  input wire logic rd,
  input wire logic [15:0] rdata,
  input wire logic output_enable,
  input wire logic [7:0] message,
  input wire logic message_valid,
  input wire contact_pkg::status_pins_t status_pins
);
  // Single domain, so clock and reset are given once
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Status pins and read data
  a_pwr_off_idle: assert property (status_pins.power_off_n)
    else $error("power off status not idle high");
  a_out_on_low: assert property (
    status_pins.output_on_n == !$past(output_enable))
    else $error("output on status does not track output");
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 16'h0000)
    else $error("read data outside read slot");
  // A shutdown contact held closed for 12 cycles must have won
  a_shutdown_off: assert property (
    !contact_pins.shutdown_input [*8]
    ##1 !contact_pins.shutdown_input [*4]
    |-> !output_enable && !status_pins.alarm_n)
    else $error("shutdown contact did not remove output");
  a_trip_alarm: assert property (
    protection_trip |-> ##[1:3] !status_pins.alarm_n)
    else $error("trip did not raise alarm status");
  // Messages only come from a refused key press
  a_msg_code: assert property (
    message_valid |-> message inside {8'h01, 8'h02})
    else $error("message code out of set");
  a_msg_pulse: assert property (message_valid |=> !message_valid)
    else $error("message strobe longer than one cycle");
  a_msg_cause: assert property (message_valid |-> $past(output_key))
    else $error("message without key press");
  a_msg_refused: assert property (message_valid |-> !output_enable)
    else $error("output on despite refused key");

  c_message: cover property (message_valid);
  c_alarm: cover property (!status_pins.alarm_n);
  c_output_on: cover property (output_enable);
endmodule // contact_monitor

bind output_contact_control contact_monitor #(
  .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)
) contact_monitor_inst (
  .ref_clk(ref_clk),
  .rst(rst),
  .contact_pins(contact_pins),
  .output_key(output_key),
  .protection_trip(protection_trip),
  .rd(rd),
  .rdata(rdata),
  .output_enable(output_enable),
  .message(message),
  .message_valid(message_valid),
  .status_pins(status_pins)
);
`default_nettype wire

// ---- testbench/contact_switch_model.sv ----
// Purpose: Switches or relays wired from each contact to common
// Assumes: Pull-ups inside the device, no bounce modelled
// Notes: A closed switch pulls the pin to common
`timescale 1ns/1ps
`default_nettype none
module contact_switch_model (
  input wire logic switch_closed,
  input wire logic shutdown_closed,
  input wire logic clear_closed,
  output var contact_pkg::contacts_t pins
);
  // Open contact floats to the pull-up level
  always_comb
  begin
    pins.output_switch_input = !switch_closed;
    pins.shutdown_input = !shutdown_closed;
    pins.alarm_clear_input = !clear_closed;
  end
endmodule // contact_switch_model
`default_nettype wire

// ---- testbench/tb_output_contact_control.sv ----
// Purpose: Directed bench for the output contact control block
// Assumes: Debounce and delay tick shortened to 4 cycles
// Notes: Polarity changes need a reset pulse to go live
`timescale 1ns/1ps
`default_nettype none
module tb_output_contact_control;
  logic ref_clk, rst, output_key, alarm_clear_key, protection_trip;
  logic cv_mode, cc_mode, wr, rd, sw_closed, sd_closed, clr_closed;
  logic [3:0] addr;
  logic [15:0] wdata, rdata, rv;
  logic output_enable, message_valid, irq;
  logic [7:0] message;
  contact_pkg::contacts_t contact_pins;
  contact_pkg::status_pins_t status_pins;
  int mismatches, total_checks;

  contact_switch_model contact_switch_model_inst (.switch_closed(sw_closed),
    .shutdown_closed(sd_closed), .clear_closed(clr_closed),
    .pins(contact_pins));
  output_contact_control #(.DEBOUNCE_CYCLES(4), .DELAY_TICK_CYCLES(4))
    output_contact_control_inst (.ref_clk(ref_clk), .rst(rst),
    .contact_pins(contact_pins), .output_key(output_key),
    .alarm_clear_key(alarm_clear_key), .protection_trip(protection_trip),
    .cv_mode(cv_mode), .cc_mode(cc_mode), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .output_enable(output_enable),
    .message(message), .message_valid(message_valid),
    .status_pins(status_pins), .irq(irq));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
    #1;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask

  // Contacts settle through sync and debounce before checks
  task automatic contacts(input logic sw, input logic sd, input logic cl);
    @(posedge ref_clk);
    sw_closed <= sw;
    sd_closed <= sd;
    clr_closed <= cl;
    repeat (12) @(posedge ref_clk);
    #1;
  endtask

  task automatic press(input logic exp_mv);
    @(posedge ref_clk);
    output_key <= 1'b1;
    @(posedge ref_clk);
    output_key <= 1'b0;
    #1 chk(message_valid, exp_mv);
  endtask

  task automatic power_cycle();
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
  endtask

  // Contact polarity 0 or 1: follows switch, refuses key with a message
  task automatic t_contact(input logic [1:0] pol, input logic [1:0] prev);
    wr_reg(contact_pkg::ADDR_CTRL, {14'h0000, pol});
    rd_reg(contact_pkg::ADDR_CTRL);
    chk(rv[5:4], prev);
    power_cycle();
    rd_reg(contact_pkg::ADDR_CTRL);
    chk(rv[5:4], pol);
    wr_reg(contact_pkg::ADDR_DELAY, 16'hFFFF);
    contacts(pol[0], 1'b0, 1'b0);
    chk(output_enable, 1'b1);
    contacts(!pol[0], 1'b0, 1'b0);
    chk(output_enable, 1'b0);
    press(1'b1);
    chk(message, pol[0] ? 8'h02 : 8'h01);
    chk(output_enable, 1'b0);
  endtask

  // Polarity 2: switch ignored, panel key rules the output
  task automatic t_panel();
    wr_reg(contact_pkg::ADDR_CTRL, 16'h0002);
    power_cycle();
    wr_reg(contact_pkg::ADDR_DELAY, 16'h0000);
    @(posedge ref_clk);
    cv_mode <= 1'b1;
    contacts(1'b1, 1'b0, 1'b0);
    chk(output_enable, 1'b0);
    press(1'b0);
    repeat (12) @(posedge ref_clk);
    #1 chk(output_enable, 1'b1);
    chk(status_pins, 5'h16);
    @(posedge ref_clk);
    cv_mode <= 1'b0;
    cc_mode <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 chk(status_pins, 5'h1C);
    contacts(1'b0, 1'b0, 1'b0);
    chk(output_enable, 1'b1);
  endtask

  // Shutdown latch, key clear, trip and contact clear, interrupt
  task automatic t_shutdown();
    wr_reg(contact_pkg::ADDR_EVENT, 16'h000F);
    wr_reg(contact_pkg::ADDR_MASK, 16'h0000);
    contacts(1'b0, 1'b1, 1'b0);
    chk(output_enable, 1'b0);
    chk(status_pins.alarm_n, 1'b0);
    chk(irq, 1'b0);
    wr_reg(contact_pkg::ADDR_MASK, 16'h000F);
    chk(irq, 1'b1);
    // A clear while the contact is still closed must not release
    @(posedge ref_clk);
    alarm_clear_key <= 1'b1;
    @(posedge ref_clk);
    alarm_clear_key <= 1'b0;
    rd_reg(contact_pkg::ADDR_STATUS);
    chk(rv[4], 1'b1);
    contacts(1'b0, 1'b0, 1'b0);
    rd_reg(contact_pkg::ADDR_STATUS);
    chk(rv[4], 1'b1);
    chk(output_enable, 1'b0);
    @(posedge ref_clk);
    alarm_clear_key <= 1'b1;
    @(posedge ref_clk);
    alarm_clear_key <= 1'b0;
    rd_reg(contact_pkg::ADDR_STATUS);
    chk(rv[5:4], 2'h0);
    press(1'b0);
    repeat (12) @(posedge ref_clk);
    #1 chk(output_enable, 1'b1);
    @(posedge ref_clk);
    protection_trip <= 1'b1;
    @(posedge ref_clk);
    protection_trip <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 chk(status_pins.alarm_n, 1'b0);
    contacts(1'b0, 1'b0, 1'b1);
    rd_reg(contact_pkg::ADDR_STATUS);
    chk(rv[5], 1'b0);
    wr_reg(contact_pkg::ADDR_EVENT, 16'h000F);
    chk(irq, 1'b0);
    wr_reg(contact_pkg::ADDR_MASK, 16'h0000);
  endtask

  // Free-running reference clock
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // Watchdog well beyond the expected run length
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    end_sim();
  end

  initial
  begin
    {rst, output_key, alarm_clear_key, protection_trip} = 4'hF;
    {cv_mode, cc_mode, wr, rd, sw_closed, sd_closed, clr_closed} = 7'h00;
    addr = 4'h0;
    wdata = 16'h0000;
    mismatches = 0;
    total_checks = 0;
    {output_key, alarm_clear_key, protection_trip} = 3'h0;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    #1 chk(status_pins, 5'h1F);
    rd_reg(contact_pkg::ADDR_CTRL);
    chk(rv[5:4], 2'h2);
    rd_reg(4'h9);
    chk(rv, 16'h0000);
    t_contact(2'h0, 2'h2);
    t_contact(2'h1, 2'h0);
    t_panel();
    t_shutdown();
    end_sim();
  end
endmodule // tb_output_contact_control
`default_nettype wire
